/* File: hw/pgt_top.sv */
// gate-in-panel timing, strap combining, lane remap and low-supply discharge
// Overview of operation
// - upper nibble: lines from discharge pulse rise to start pulse 1 rise
// - lower nibble: lines from discharge pulse fall to start pulse 1 rise
// - charge share per edge: zero off, else code times half microsecond
// - gate control bit 6 staggers the two frame polarity signals
// - two-bit discharge pulse stagger: off, 0.5, 1, 1.5 microseconds
// - bit 3 picks 2-phase or 4-phase discharge pulse staggering
// - stopped gate clocks: bit 2 adds discharge pulse, bit 1 held level
// - bit 0: start pulse and gate clock overlap or stagger
// - shift scale bit: step of 8 or 24 clocks
// - on overlap, shift bit separates by one or two lines
// - MIPI: gate clock timing follows enable rising or falling edge
// - bit 5 measures line length and count instead of fixed line length and resolution-set line count
// - MIPI: bit 4 makes timing follow host sync pulses
// - soft reset register 00 holds reset, 01 runs normal display
// - strap settings are pin XOR register; standby 0, normal 1
// - MIPI lane swap code maps four lanes to pads, clock fixed
// - LVDS four-bit swap code picks one of ten pad assignments
// - combined self-test select: 0 test pattern, 1 normal
// - combined lane count: 10 three lanes, 11 four lanes
// - combined polarity: 0 swaps wires, 1 normal
// - low supply forces discharge: grounds outputs, gates high, pump stopped
// - supply dips shorter than 20 microseconds are ignored
`timescale 1ns/100ps
module pgt_top import pgt_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [11:0] RES_LINES_ALT = RES_LINES_DEFAULT,
  parameter logic [15:0] H_CYCLES_DEFAULT = 16'h0400
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  output logic [7:0] cmd_rdata_out,
  input wire logic lvds_mode_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic de_in,
  input wire logic standby_pin_in,
  input wire logic selftest_pin_in,
  input wire logic polarity_pin_in,
  input wire logic [1:0] lane_swap_pin_in,
  input wire logic [1:0] lane_swap_otp_in,
  input wire logic [1:0] lane_count_pin_in,
  input wire logic [2:0] resolution_pin_in,
  input wire logic [1:0] power_scheme_pin_in,
  input wire logic supply_low_in,
  output logic standby_control_out,
  output logic selftest_select_out,
  output logic wire_polarity_swap_out,
  output logic [1:0] lane_count_out,
  output logic [2:0] resolution_code_out,
  output logic [1:0] power_scheme_code_out,
  output logic [14:0] pad_lane_map_out,
  output logic soft_reset_hold_out,
  output logic [4:0] gate_high_level_code_out,
  output logic negative_pump_rate_out,
  output logic [4:0] gate_shift_step_out,
  output logic [15:0] h_total_out,
  output logic [11:0] v_total_out,
  output logic vertical_start_pulse_1_out,
  output logic [3:0] gate_clock_out,
  output logic charge_share_out,
  output logic [1:0] frame_polarity_out,
  output logic discharge_active_out,
  output logic source_to_ground_out,
  output logic common_to_ground_out,
  output logic pump_stop_out
);
  logic [7:0] dist_reg, share_reg, gate_reg, shift_reg, learn_reg, hsref_reg;
  logic [7:0] npump_reg, vgh_reg, srst_reg, lanes_reg, strap_reg, res_reg;

  // pad order D0, D1, CLK, D2, D3; undefined LVDS codes leave pads idle
  function automatic logic [14:0] lane_map(input logic lvds, input logic [3:0] code);
    logic [14:0] m;
    m = {5{SRC_NONE}};
    if (!lvds) begin
      case (code[1:0])
        2'h0: m = {SRC_L3, SRC_L2, SRC_CLK, SRC_L1, SRC_L0};
        2'h1: m = {SRC_L3, SRC_L0, SRC_CLK, SRC_L1, SRC_L2};
        2'h2: m = {SRC_L0, SRC_L1, SRC_CLK, SRC_L2, SRC_L3};
        default: m = {SRC_L2, SRC_L1, SRC_CLK, SRC_L0, SRC_L3};
      endcase
    end else begin
      case (code)
        4'h0: m = {SRC_L3, SRC_L2, SRC_CLK, SRC_L1, SRC_L0};
        4'h1: m = {SRC_L3, SRC_CLK, SRC_L2, SRC_L1, SRC_L0};
        4'h2: m = {SRC_L0, SRC_L1, SRC_CLK, SRC_L2, SRC_L3};
        4'h3: m = {SRC_L0, SRC_L1, SRC_L2, SRC_CLK, SRC_L3};
        4'h4: m = {SRC_CLK, SRC_L0, SRC_L1, SRC_L2, SRC_L3};
        4'h5: m = {SRC_CLK, SRC_L3, SRC_L2, SRC_L1, SRC_L0};
        4'h6: m = {SRC_L3, SRC_L2, SRC_L1, SRC_L0, SRC_CLK};
        4'h7: m = {SRC_L0, SRC_L1, SRC_L2, SRC_L3, SRC_CLK};
        4'h8: m = {SRC_L3, SRC_L0, SRC_CLK, SRC_L1, SRC_L2};
        4'h9: m = {SRC_L2, SRC_L1, SRC_CLK, SRC_L0, SRC_L3};
        default: m = {5{SRC_NONE}};
      endcase
    end
    return m;
  endfunction

  // register writes; unmapped and read-only addresses are ignored
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dist_reg <= RST_DISCHARGE_DIST;
      share_reg <= RST_CHARGE_SHARE;
      gate_reg <= RST_GATE_PULSE;
      shift_reg <= RST_GATE_SHIFT;
      learn_reg <= RST_TIMING_LEARN;
      hsref_reg <= RST_HOST_SYNC;
      npump_reg <= RST_NEG_PUMP;
      vgh_reg <= RST_GATE_HIGH;
      srst_reg <= RST_SOFT_RESET;
      lanes_reg <= RST_LANE_COUNT;
      strap_reg <= RST_STRAP_INV;
      res_reg <= RST_RESOLUTION;
    end else if (ce_in && cmd_wr_in) begin
      case (cmd_addr_in)
        ADDR_DISCHARGE_DIST: dist_reg <= cmd_wdata_in;
        ADDR_CHARGE_SHARE: share_reg <= cmd_wdata_in;
        ADDR_GATE_PULSE: gate_reg <= cmd_wdata_in;
        ADDR_GATE_SHIFT: shift_reg <= cmd_wdata_in;
        ADDR_TIMING_LEARN: learn_reg <= cmd_wdata_in;
        ADDR_HOST_SYNC: hsref_reg <= cmd_wdata_in;
        ADDR_NEG_PUMP: npump_reg <= cmd_wdata_in;
        ADDR_GATE_HIGH: vgh_reg <= cmd_wdata_in;
        ADDR_SOFT_RESET: srst_reg <= cmd_wdata_in;
        ADDR_LANE_COUNT: lanes_reg <= cmd_wdata_in;
        ADDR_STRAP_INV: strap_reg <= cmd_wdata_in;
        ADDR_RESOLUTION: res_reg <= cmd_wdata_in;
        default: ;
      endcase
    end
  end

  // read selection; unmapped addresses read zero
  logic [7:0] read_value;
  always_comb begin
    case (cmd_addr_in)
      ADDR_DISCHARGE_DIST: read_value = dist_reg;
      ADDR_CHARGE_SHARE: read_value = share_reg;
      ADDR_GATE_PULSE: read_value = gate_reg;
      ADDR_GATE_SHIFT: read_value = shift_reg;
      ADDR_TIMING_LEARN: read_value = learn_reg;
      ADDR_HOST_SYNC: read_value = hsref_reg;
      ADDR_NEG_PUMP: read_value = npump_reg;
      ADDR_GATE_HIGH: read_value = vgh_reg;
      ADDR_SOFT_RESET: read_value = srst_reg;
      ADDR_MAKER_ID: read_value = MAKER_ID;
      ADDR_LANE_COUNT: read_value = lanes_reg;
      ADDR_STRAP_INV: read_value = strap_reg;
      ADDR_RESOLUTION: read_value = res_reg;
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) cmd_rdata_out <= 8'h00;
    else if (ce_in && cmd_rd_in) cmd_rdata_out <= read_value;
  end

  // strap combining: pin level XOR register bit, straight through to the core
  wire [1:0] swap_code = lane_swap_pin_in ^ strap_reg[SI_SWAP_LSB +: 2];
  assign standby_control_out = standby_pin_in ^ strap_reg[SI_STANDBY];
  assign selftest_select_out = selftest_pin_in ^ strap_reg[SI_SELFTEST];
  assign wire_polarity_swap_out = polarity_pin_in ^ strap_reg[SI_POLARITY];
  assign lane_count_out = lane_count_pin_in ^ lanes_reg[LC_LSB +: 2];
  assign resolution_code_out = resolution_pin_in ^ res_reg[2:0];
  assign power_scheme_code_out = power_scheme_pin_in ^ strap_reg[SI_POWER_LSB +: 2];
  assign pad_lane_map_out = lane_map(lvds_mode_in, {lane_swap_otp_in, swap_code});
  assign soft_reset_hold_out = !srst_reg[SR_RELEASE];
  assign gate_high_level_code_out = vgh_reg[4:0];
  assign negative_pump_rate_out = npump_reg[4];
  assign gate_shift_step_out = shift_reg[GS_SCALE] ? SHIFT_STEP_COARSE : SHIFT_STEP_FINE;

  // timing runs only when released from soft reset and not in standby
  wire run = !soft_reset_hold_out && standby_control_out;
  wire step = ce_in;

  // line reference selection
  logic de_q;
  wire mipi = !lvds_mode_in;
  wire use_host = mipi && hsref_reg[HS_REF];
  wire de_edge = (mipi && learn_reg[TL_EDGE]) ? (de_q && !de_in) : (de_in && !de_q);
  wire line_evt = use_host ? hsync_in : de_edge;
  wire frame_evt = vsync_in;

  logic [11:0] line_cnt, v_meas;
  logic [15:0] h_cnt, h_meas;

  // line counter and measurement of line length and line count
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      de_q <= 1'b0;
      line_cnt <= LINE_MAX;
      h_cnt <= 16'h0000;
      h_meas <= 16'h0000;
      v_meas <= 12'h000;
    end else if (step) begin
      de_q <= de_in;
      if (!run) begin
        line_cnt <= LINE_MAX;
        h_cnt <= 16'h0000;
      end else if (frame_evt) begin
        line_cnt <= 12'h000;
        v_meas <= line_cnt;
      end else if (line_evt) begin
        line_cnt <= (line_cnt == LINE_MAX) ? LINE_MAX : line_cnt + LINE_ONE;
        h_meas <= h_cnt;
        h_cnt <= 16'h0001; // the reference cycle itself belongs to the line
      end else if (h_cnt != 16'hffff) begin
        h_cnt <= h_cnt + 16'h0001;
      end
    end
  end

  // measured values, or the fixed line length and the line count from the resolution setting
  wire [11:0] res_lines = (resolution_code_out == 3'h0) ? RES_LINES_DEFAULT : RES_LINES_ALT;
  assign h_total_out = learn_reg[TL_MEASURE] ? h_meas : H_CYCLES_DEFAULT;
  assign v_total_out = learn_reg[TL_MEASURE] ? v_meas : res_lines;

  // discharge window in lines before start pulse 1; empty if rise is closer
  wire [11:0] win_open = STV_LINE - {8'h00, dist_reg[FLD_HI_LSB +: 4]};
  wire [11:0] win_close = STV_LINE - {8'h00, dist_reg[3:0]};
  wire blank_win = gate_reg[GP_DISCHARGE_EN] && line_cnt >= win_open
                   && line_cnt < win_close;
  wire stv_now = line_cnt >= STV_LINE && line_cnt < STV_LINE + STV_WIDTH;
  // overlap starts clocks one or two lines after the start pulse rises, stagger after it ends
  wire [11:0] ovl_shift = shift_reg[GS_SHIFT2] ? LINE_TWO : LINE_ONE;
  wire [11:0] clk_start = STV_LINE + (gate_reg[GP_STV_STAGGER] ? STV_WIDTH : ovl_shift);
  wire running = line_cnt >= clk_start && line_cnt != LINE_MAX;

  // gate clock edges land one shift step after each line reference
  logic [4:0] dly_cnt;
  logic clk_phase;
  wire tick = dly_cnt == 5'h01;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dly_cnt <= 5'h00;
      clk_phase <= 1'b0;
    end else if (step) begin
      if (line_evt) dly_cnt <= gate_shift_step_out;
      else if (dly_cnt != 5'h00) dly_cnt <= dly_cnt - 5'h01;
      if (!running) clk_phase <= 1'b0;
      else if (tick) clk_phase <= !clk_phase;
    end
  end

  // cycles since the discharge window last changed, for staggering
  logic win_q;
  logic [15:0] since_cnt;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      win_q <= 1'b0;
      since_cnt <= 16'h0000;
    end else if (step) begin
      win_q <= blank_win;
      if (blank_win != win_q) since_cnt <= 16'h0000;
      else if (since_cnt != 16'hffff) since_cnt <= since_cnt + 16'h0001;
    end
  end

  // per-phase gate clock: running, discharge pulse or held level
  logic [3:0] gclk_next;
  logic discharge_on;
  for (genvar i = 0; i < 4; i++) begin : g_phase
    wire [1:0] idx = gate_reg[GP_PHASE4] ? 2'(i) : 2'(i % 2);
    wire [15:0] dly = 16'(gate_reg[GP_STAGGER_LSB +: 2] * idx * SHARE_STEP_CYC);
    wire pulse = win_q ? (since_cnt >= dly) : (since_cnt < dly);
    assign gclk_next[i] = discharge_on ? 1'b1
                        : running ? (clk_phase ^ idx[0])
                        : (gate_reg[GP_DISCHARGE_EN] && pulse) ? 1'b1
                        : gate_reg[GP_HOLD_LEVEL];
  end

  // charge share pulse after each edge of the first gate clock
  logic [9:0] share_cnt;
  wire g_rise = gclk_next[0] && !gate_clock_out[0];
  wire g_fall = !gclk_next[0] && gate_clock_out[0];
  wire [9:0] rise_len = 10'(share_reg[3:0] * SHARE_STEP_CYC);
  wire [9:0] fall_len = 10'(share_reg[FLD_HI_LSB +: 4] * SHARE_STEP_CYC);
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gate_clock_out <= 4'h0;
      share_cnt <= 10'h000;
      vertical_start_pulse_1_out <= 1'b0;
    end else if (step) begin
      gate_clock_out <= gclk_next;
      vertical_start_pulse_1_out <= stv_now && run && !discharge_on;
      if (g_rise) share_cnt <= rise_len;
      else if (g_fall) share_cnt <= fall_len;
      else if (share_cnt != 10'h000) share_cnt <= share_cnt - 10'h001;
    end
  end
  assign charge_share_out = share_cnt != 10'h000;

  // frame polarity: second signal lags one line when staggered
  logic pol_pend;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_polarity_out <= 2'h0;
      pol_pend <= 1'b0;
    end else if (step && run) begin
      if (frame_evt) begin
        frame_polarity_out[0] <= !frame_polarity_out[0];
        if (!gate_reg[GP_FRAME_STAGGER]) frame_polarity_out[1] <= !frame_polarity_out[0];
        pol_pend <= gate_reg[GP_FRAME_STAGGER];
      end else if (pol_pend && line_evt) begin
        frame_polarity_out[1] <= frame_polarity_out[0];
        pol_pend <= 1'b0;
      end
    end
  end

  // low supply debounce; a short dip restarts the count and never trips
  logic [11:0] deb_cnt;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      deb_cnt <= 12'h000;
      discharge_on <= 1'b0;
    end else if (step) begin
      if (!supply_low_in) deb_cnt <= 12'h000;
      else if (deb_cnt != 12'(DEBOUNCE_CYC)) deb_cnt <= deb_cnt + 12'h001;
      discharge_on <= supply_low_in && deb_cnt == 12'(DEBOUNCE_CYC);
    end
  end
  assign discharge_active_out = discharge_on;
  assign source_to_ground_out = discharge_on;
  assign common_to_ground_out = discharge_on;
  assign pump_stop_out = discharge_on;
endmodule

/* File: hw/pgt_pkg.sv */
// constants for the panel gate timing and strap configuration block
package pgt_pkg;
  // register byte addresses on the command interface
  localparam logic [7:0] ADDR_DISCHARGE_DIST = 8'h6a;
  localparam logic [7:0] ADDR_CHARGE_SHARE = 8'h6b;
  localparam logic [7:0] ADDR_GATE_PULSE = 8'h6c;
  localparam logic [7:0] ADDR_GATE_SHIFT = 8'h6d;
  localparam logic [7:0] ADDR_TIMING_LEARN = 8'h73;
  localparam logic [7:0] ADDR_HOST_SYNC = 8'h74;
  localparam logic [7:0] ADDR_NEG_PUMP = 8'h77;
  localparam logic [7:0] ADDR_GATE_HIGH = 8'h78;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h7b;
  localparam logic [7:0] ADDR_MAKER_ID = 8'hfa;
  localparam logic [7:0] ADDR_LANE_COUNT = 8'h63;
  localparam logic [7:0] ADDR_STRAP_INV = 8'he0;
  localparam logic [7:0] ADDR_RESOLUTION = 8'he1;

  // reset values
  localparam logic [7:0] RST_DISCHARGE_DIST = 8'ha2;
  localparam logic [7:0] RST_CHARGE_SHARE = 8'h00;
  localparam logic [7:0] RST_GATE_PULSE = 8'h08;
  localparam logic [7:0] RST_GATE_SHIFT = 8'h01;
  localparam logic [7:0] RST_TIMING_LEARN = 8'h31;
  localparam logic [7:0] RST_HOST_SYNC = 8'h10;
  localparam logic [7:0] RST_NEG_PUMP = 8'h10;
  localparam logic [7:0] RST_GATE_HIGH = 8'h47;
  localparam logic [7:0] RST_SOFT_RESET = 8'h01;
  localparam logic [7:0] RST_LANE_COUNT = 8'h06;
  localparam logic [7:0] RST_STRAP_INV = 8'h00;
  localparam logic [7:0] RST_RESOLUTION = 8'h00;

  // field positions
  localparam int FLD_HI_LSB = 4;       // upper nibble fields
  localparam int GP_FRAME_STAGGER = 6;
  localparam int GP_STAGGER_LSB = 4;
  localparam int GP_PHASE4 = 3;
  localparam int GP_DISCHARGE_EN = 2;
  localparam int GP_HOLD_LEVEL = 1;
  localparam int GP_STV_STAGGER = 0;
  localparam int GS_SCALE = 4;
  localparam int GS_SHIFT2 = 0;
  localparam int TL_MEASURE = 5;
  localparam int TL_EDGE = 4;
  localparam int HS_REF = 4;
  localparam int SR_RELEASE = 0;
  localparam int LC_LSB = 5;
  localparam int SI_STANDBY = 0;
  localparam int SI_SELFTEST = 1;
  localparam int SI_POLARITY = 2;
  localparam int SI_SWAP_LSB = 3;
  localparam int SI_POWER_LSB = 5;

  // lane source codes on the pads
  localparam logic [2:0] SRC_L0 = 3'h0;
  localparam logic [2:0] SRC_L1 = 3'h1;
  localparam logic [2:0] SRC_L2 = 3'h2;
  localparam logic [2:0] SRC_L3 = 3'h3;
  localparam logic [2:0] SRC_CLK = 3'h4;
  localparam logic [2:0] SRC_NONE = 3'h7;

  // gate timing line positions after frame start
  localparam logic [11:0] STV_LINE = 12'h00f;
  localparam logic [11:0] STV_WIDTH = 12'h002;
  localparam logic [11:0] LINE_ONE = 12'h001;
  localparam logic [11:0] LINE_TWO = 12'h002;
  localparam logic [11:0] LINE_MAX = 12'hfff;

  // timing in its own unit, cycle counts derived from the clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int SHARE_STEP_NS = 500;
  localparam int DEBOUNCE_NS = 20000;
  localparam int SHARE_STEP_CYC = (SHARE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SHIFT_STEP_FINE = 5'h08;
  localparam logic [4:0] SHIFT_STEP_COARSE = 5'h18;
  localparam logic [11:0] RES_LINES_DEFAULT = 12'h500;
endpackage

/* File: verif/pgt_sva.sv */
// assertion checker for the panel gate timing and strap block
`timescale 1ns/100ps
module pgt_chk import pgt_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h5a
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic [7:0] cmd_rdata_out,
  input wire logic lvds_mode_in,
  input wire logic standby_pin_in,
  input wire logic supply_low_in,
  input wire logic standby_control_out,
  input wire logic [14:0] pad_lane_map_out,
  input wire logic soft_reset_hold_out,
  input wire logic [4:0] gate_shift_step_out,
  input wire logic vertical_start_pulse_1_out,
  input wire logic [3:0] gate_clock_out,
  input wire logic discharge_active_out,
  input wire logic source_to_ground_out,
  input wire logic common_to_ground_out,
  input wire logic pump_stop_out
);
  logic [15:0] low_cnt;
  logic wr_go;
  assign wr_go = ce_in && cmd_wr_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // consecutive low-supply cycles, saturating so a long dip never wraps round
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) low_cnt <= 16'h0000;
    else if (!supply_low_in) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
  end
  soft_hold_a: assert property (wr_go && cmd_addr_in == ADDR_SOFT_RESET
    |=> soft_reset_hold_out == !$past(cmd_wdata_in[0])) else $error("soft reset hold wrong");
  strap_xor_a: assert property ($changed(standby_pin_in) && !$past(wr_go)
    |-> $changed(standby_control_out)) else $error("standby strap not combined");
  shift_step_a: assert property (wr_go && cmd_addr_in == ADDR_GATE_SHIFT
    |=> gate_shift_step_out == ($past(cmd_wdata_in[GS_SCALE]) ? SHIFT_STEP_COARSE
    : SHIFT_STEP_FINE)) else $error("shift step wrong");
  maker_read_a: assert property (ce_in && cmd_rd_in && cmd_addr_in == ADDR_MAKER_ID
    |=> cmd_rdata_out == MAKER_ID) else $error("maker identifier read wrong");
  // discharge may only rise once the dip has outlasted the whole debounce span
  dip_ignore_a: assert property ($rose(discharge_active_out)
    |-> low_cnt > 16'(DEBOUNCE_CYC)) else $error("discharge before debounce");
  long_dip_a: assert property (low_cnt == 16'(DEBOUNCE_CYC) + 16'h0001
    |-> discharge_active_out) else $error("discharge missing on long dip");
  // gate clocks are registered, so they reach the high level one cycle later
  discharge_out_a: assert property (discharge_active_out
    |-> source_to_ground_out && common_to_ground_out && pump_stop_out
    ##1 gate_clock_out == 4'hf) else $error("discharge outputs incomplete");
  discharge_end_a: assert property ($fell(supply_low_in)
    |-> ##[0:3] !discharge_active_out) else $error("discharge not ended");
  clock_pad_a: assert property (!lvds_mode_in
    |-> pad_lane_map_out[8:6] == SRC_CLK) else $error("clock pad not on clock");
  hold_quiet_a: assert property (soft_reset_hold_out[*3]
    |-> vertical_start_pulse_1_out == 1'b0) else $error("start pulse during hold");
endmodule
bind pgt_top pgt_chk #(.MAKER_ID(MAKER_ID)) pgt_chk_i (.*);

/* File: verif/pgt_panel_model.sv */
// behavioural gate shift register on the panel, counting scan steps
`timescale 1ns/100ps
module pgt_panel_model (
  input wire logic start_in,
  input wire logic [3:0] gate_clk_in,
  output logic [7:0] rows_out,
  output logic all_high_out
);
  // no reset pin on a panel: a start pulse restarts the scan count
  initial rows_out = 8'h00;
  always @(posedge gate_clk_in[0] or posedge start_in) begin
    if (start_in) rows_out <= 8'h00;
    else rows_out <= rows_out + 8'h01;
  end
  // all gate lines high means the whole panel is being discharged
  assign all_high_out = &gate_clk_in;
endmodule

/* File: verif/pgt_top_tb.sv */
// self-checking bench for the panel gate timing and strap block
`timescale 1ns/100ps
module pgt_top_tb import pgt_pkg::*;;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_in = 1'b1;
  logic cmd_wr_in = 1'b0;
  logic cmd_rd_in = 1'b0;
  logic [7:0] cmd_addr_in = 8'h00;
  logic [7:0] cmd_wdata_in = 8'h00;
  logic lvds_mode_in = 1'b0;
  logic hsync_in = 1'b0;
  logic vsync_in = 1'b0;
  logic de_in = 1'b0;
  logic standby_pin_in = 1'b1;
  logic selftest_pin_in = 1'b1;
  logic polarity_pin_in = 1'b1;
  logic [1:0] lane_swap_pin_in = 2'h0;
  logic [1:0] lane_swap_otp_in = 2'h0;
  logic [1:0] lane_count_pin_in = 2'h1;
  logic [2:0] resolution_pin_in = 3'h3;
  logic [1:0] power_scheme_pin_in = 2'h1;
  logic supply_low_in = 1'b0;
  logic [7:0] cmd_rdata_out;
  logic standby_control_out, selftest_select_out, wire_polarity_swap_out, soft_reset_hold_out;
  logic negative_pump_rate_out, vertical_start_pulse_1_out, charge_share_out;
  logic discharge_active_out, source_to_ground_out, common_to_ground_out, pump_stop_out;
  logic [1:0] lane_count_out, power_scheme_code_out, frame_polarity_out;
  logic [2:0] resolution_code_out;
  logic [14:0] pad_lane_map_out;
  logic [4:0] gate_high_level_code_out, gate_shift_step_out;
  logic [15:0] h_total_out;
  logic [11:0] v_total_out;
  logic [3:0] gate_clock_out;
  logic [7:0] rows, rows_kept, got;
  logic all_high;
  logic [3:0] code;
  int err_count = 0;
  int tests_run = 0;
  // register rows: address, reset value, data written, value read back
  logic [31:0] regs [12] = '{32'h6aa25a5a, 32'h6b00a5a5, 32'h6c083c3c, 32'h6d011111,
    32'h73313131, 32'h74101010, 32'h77100000, 32'h78471f1f, 32'h7b010101, 32'hfa3c003c,
    32'h5500ff00, 32'he0000808};
  // pad maps, one octal digit a pad: four codes on one link, ten and a reserved one on the other
  logic [14:0] maps [15] = '{15'o32410, 15'o30412, 15'o01423, 15'o21403, 15'o32410,
    15'o34210, 15'o01423, 15'o01243, 15'o40123, 15'o43210, 15'o32104, 15'o01234,
    15'o30412, 15'o21403, 15'o77777};
  // identifier value 8'h3c is arbitrary
  pgt_top #(.MAKER_ID(8'h3c)) pgt_top_i (.*);
  pgt_panel_model pgt_panel_model_i (.start_in(vertical_start_pulse_1_out),
    .gate_clk_in(gate_clock_out), .rows_out(rows), .all_high_out(all_high));
  always #4 clock_in = ~clock_in;
  // shared compare, write, read and sync helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in) #1;
    cmd_wr_in = 1'b1;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    @(posedge clock_in) #1;
    cmd_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in) #1;
    cmd_rd_in = 1'b1;
    cmd_addr_in = a;
    @(posedge clock_in) #1;
    cmd_rd_in = 1'b0;
    d = cmd_rdata_out;
  endtask
  task automatic lines(input int n);
    repeat (n) begin
      @(posedge clock_in) #1;
      hsync_in = 1'b1;
      @(posedge clock_in) #1;
      hsync_in = 1'b0;
      repeat (38) @(posedge clock_in);
    end
    #1;
  endtask
  task automatic frame_start();
    @(posedge clock_in) #1;
    vsync_in = 1'b1;
    @(posedge clock_in) #1;
    vsync_in = 1'b0;
  endtask
  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clock_in);
    #1 resetn_in = 1'b1;
    for (int i = 0; i < 12; i++) begin
      rd(regs[i][31:24], got);
      chk("reset value", 16'(regs[i][23:16]), 16'(got));
      wr(regs[i][31:24], regs[i][15:8]);
      rd(regs[i][31:24], got);
      chk("readback", 16'(regs[i][7:0]), 16'(got));
    end
    chk("shift step", 16'(SHIFT_STEP_COARSE), 16'(gate_shift_step_out));
    chk("gate high code", 16'h001f, 16'(gate_high_level_code_out));
    chk("pump rate", 16'h0000, 16'(negative_pump_rate_out));
    // a write with the clock enable low must leave the register alone
    ce_in = 1'b0;
    wr(ADDR_CHARGE_SHARE, 8'hff);
    ce_in = 1'b1;
    rd(ADDR_CHARGE_SHARE, got);
    chk("frozen write", 16'h00a5, 16'(got));
    // one frame on host sync: start pulse on lines 15 and 16, then scanning
    frame_start();
    lines(14);
    chk("pulse early", 16'h0000, 16'(vertical_start_pulse_1_out));
    lines(1);
    chk("pulse", 16'h0001, 16'(vertical_start_pulse_1_out));
    lines(6);
    chk("pulse late", 16'h0000, 16'(vertical_start_pulse_1_out));
    chk("phase pair", 16'(!gate_clock_out[0]), 16'(gate_clock_out[1]));
    chk("panel scan", 16'h0001, 16'(rows != 8'h00));
    // lines are 40 cycles apart; a gate clock edge came 13 cycles ago
    chk("line length", 16'h0028, h_total_out);
    chk("charge share", 16'h0001, 16'(charge_share_out));
    chk("frame polarity", 16'h0003, 16'(frame_polarity_out));
    // held in soft reset, a frame gives neither pulse nor scan
    wr(ADDR_SOFT_RESET, 8'h00);
    chk("hold on", 16'h0001, 16'(soft_reset_hold_out));
    rows_kept = rows;
    frame_start();
    lines(15);
    chk("held pulse", 16'h0000, 16'(vertical_start_pulse_1_out));
    chk("held scan", 16'(rows_kept), 16'(rows));
    wr(ADDR_SOFT_RESET, 8'h01);
    chk("hold off", 16'h0000, 16'(soft_reset_hold_out));
    // a short dip is ignored, a long one discharges the panel until supply returns
    supply_low_in = 1'b1;
    repeat (2000) @(posedge clock_in);
    #1 supply_low_in = 1'b0;
    chk("short dip", 16'h0000, 16'(discharge_active_out));
    @(posedge clock_in) #1 supply_low_in = 1'b1;
    repeat (2600) @(posedge clock_in);
    #1 chk("discharge", 16'h000f, 16'({discharge_active_out, source_to_ground_out,
      common_to_ground_out, pump_stop_out}));
    chk("gates high", 16'h0001, 16'(all_high));
    supply_low_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1 chk("discharge over", 16'h0000, 16'(discharge_active_out));
    // strap pins combined with their invert bits
    chk("straps", 16'h03ad, 16'({standby_control_out, selftest_select_out,
      wire_polarity_swap_out, lane_count_out, resolution_code_out,
      power_scheme_code_out}));
    wr(ADDR_STRAP_INV, 8'h6f);
    wr(ADDR_LANE_COUNT, 8'h60);
    wr(ADDR_RESOLUTION, 8'h05);
    chk("straps inverted", 16'h005a, 16'({standby_control_out, selftest_select_out,
      wire_polarity_swap_out, lane_count_out, resolution_code_out,
      power_scheme_code_out}));
    @(posedge clock_in) #1 standby_pin_in = 1'b0;
    #1 chk("standby pin", 16'h0001, 16'(standby_control_out));
    // measuring off: the line count follows the non-zero resolution code
    wr(ADDR_TIMING_LEARN, 8'h11);
    chk("line count", 16'(RES_LINES_DEFAULT), 16'(v_total_out));
    // every defined lane swap code on both links plus reserved LVDS code 10, low pin bit inverted by the register
    for (int i = 0; i < 15; i++) begin
      @(posedge clock_in) #1;
      lvds_mode_in = (i >= 4);
      code = 4'((i < 4) ? i : i - 4);
      lane_swap_otp_in = code[3:2];
      lane_swap_pin_in = code[1:0] ^ 2'b01;
      #1 chk("pad map", 16'(maps[i]), 16'(pad_lane_map_out));
    end
    final_report();
  end
  // watchdog: the whole run needs about 50 us
  initial begin
    #300000;
    err_count++;
    final_report();
  end
endmodule
